// File: rtl/otc_opamp_trim_control.v
// register bank and analog control outputs of the operational amplifier
`timescale 1ns/1ps
`include "otc_defines.vh"
module otc_opamp_trim_control (
   // clock and reset
   input wire clock,
   input wire reset,
   // special function register port
   input wire [7:0] sfr_addr,
   input wire sfr_write,
   input wire [7:0] sfr_wdata,
   output reg [7:0] sfr_rdata,
   // factory trim value, stable at power-on
   input wire [4:0] factory_trim,
   // comparator state from the analog core, asynchronous
   input wire analog_compare_raw,
   // analog core controls
   output reg amp_enable,
   output reg amp_output_enable,
   output reg [3:0] amp_config,
   output reg [7:0] amp_gain,
   output reg cal_mode_select,
   output reg cal_reference_select,
   output reg [4:0] offset_trim,
   // pin control
   output reg pin_digital_disable
);
   // ----------------------------------------
   // register state
   // ----------------------------------------
   reg [1:0] amp_function_select;
   reg [2:0] internal_gain_select;
   reg trim_loaded;
   reg cal_compare_result;
   reg [2:0] compare_sync;
   wire [3:0] next_config;
   wire [7:0] next_gain;
   wire [7:0] control_value;
   wire [7:0] calibration_value;
   wire compare_valid;
   wire control_hit;
   wire calibration_hit;
   wire control_write;
   wire calibration_write;
   wire compare_settled;

   // ----------------------------------------
   // next values
   // ----------------------------------------
   reg next_amp_enable;
   reg next_amp_output_enable;
   reg [1:0] next_function_select;
   reg [2:0] next_gain_select;
   reg next_cal_mode;
   reg next_cal_reference;
   reg [4:0] next_offset_trim;
   reg next_compare_result;
   reg [7:0] next_rdata;
   // reset images of the fields; flag bits ordered compare, mode, reference
   localparam [7:0] CONTROL_RESET = `OTC_CONTROL_RESET;
   localparam [2:0] CAL_FLAGS_RESET = `OTC_CAL_FLAGS_RESET;

   otc_config_decode u_decode (
      .function_select(amp_function_select),
      .gain_select(internal_gain_select),
      .config_onehot(next_config),
      .gain_onehot(next_gain)
   );

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   // other addresses are ignored for writes and read back as zero
   assign control_hit = (sfr_addr == `OTC_ADDR_CONTROL);
   assign calibration_hit = (sfr_addr == `OTC_ADDR_CALIBRATION);
   assign control_write = sfr_write && control_hit;
   assign calibration_write = sfr_write && calibration_hit;

   // ----------------------------------------
   // control register writes
   // ----------------------------------------
   always @* begin
      next_amp_enable = amp_enable;
      next_amp_output_enable = amp_output_enable;
      next_function_select = amp_function_select;
      next_gain_select = internal_gain_select;
      if (control_write) begin
         next_amp_enable = sfr_wdata[`OTC_CTL_ENABLE];
         next_amp_output_enable = sfr_wdata[`OTC_CTL_OUT_EN];
         next_function_select = sfr_wdata[`OTC_CTL_FUNC_HI:`OTC_CTL_FUNC_LO];
         next_gain_select = sfr_wdata[`OTC_CTL_GAIN_HI:`OTC_CTL_GAIN_LO];
      end
   end

   always @(posedge clock) begin
      if (reset) begin
         amp_enable <= CONTROL_RESET[`OTC_CTL_ENABLE];
         amp_output_enable <= CONTROL_RESET[`OTC_CTL_OUT_EN];
         amp_function_select <= CONTROL_RESET[`OTC_CTL_FUNC_HI:`OTC_CTL_FUNC_LO];
         internal_gain_select <= CONTROL_RESET[`OTC_CTL_GAIN_HI:`OTC_CTL_GAIN_LO];
      end else begin
         amp_enable <= next_amp_enable;
         amp_output_enable <= next_amp_output_enable;
         amp_function_select <= next_function_select;
         internal_gain_select <= next_gain_select;
      end
   end

   // ----------------------------------------
   // calibration register writes
   // ----------------------------------------
   always @* begin
      next_cal_mode = cal_mode_select;
      next_cal_reference = cal_reference_select;
      if (calibration_write) begin
         next_cal_mode = sfr_wdata[`OTC_CAL_MODE];
         next_cal_reference = sfr_wdata[`OTC_CAL_REF];
      end
   end

   always @(posedge clock) begin
      if (reset) begin
         cal_mode_select <= CAL_FLAGS_RESET[1];
         cal_reference_select <= CAL_FLAGS_RESET[0];
      end else begin
         cal_mode_select <= next_cal_mode;
         cal_reference_select <= next_cal_reference;
      end
   end

   // ----------------------------------------
   // offset trim word
   // ----------------------------------------
   // the trim word is not cleared by reset: it keeps the factory value
   // loaded once after the first reset release, so a warm reset keeps a user trim
   always @* begin
      next_offset_trim = offset_trim;
      if (!trim_loaded) begin
         next_offset_trim = factory_trim;
      end else if (calibration_write && cal_mode_select) begin
         // old mode bit gates the write, so entering calibration needs one write first
         next_offset_trim = sfr_wdata[`OTC_CAL_TRIM_HI:`OTC_CAL_TRIM_LO];
      end
   end

   // reset only holds both, so a warm reset neither reloads nor clears the trim
   always @(posedge clock) begin
      if (!reset) begin
         trim_loaded <= 1'b1;
         offset_trim <= next_offset_trim;
      end
   end

   initial trim_loaded = 1'b0;

   // ----------------------------------------
   // compare result synchroniser and qualification
   // ----------------------------------------
   assign compare_valid = cal_mode_select && amp_output_enable
      && amp_function_select == `OTC_FUNC_CAL_COMPARE;
   // a level change counts only once the last two stages agree
   assign compare_settled = (compare_sync[1] == compare_sync[2]);

   // outside the qualified setting the comparator level is meaningless, so it reads zero
   always @* begin
      next_compare_result = cal_compare_result;
      if (!compare_valid) begin
         next_compare_result = 1'b0;
      end else if (compare_settled) begin
         next_compare_result = compare_sync[2];
      end
   end

   always @(posedge clock) begin
      if (reset) begin
         compare_sync <= 3'h0;
         cal_compare_result <= CAL_FLAGS_RESET[2];
      end else begin
         compare_sync <= {compare_sync[1:0], analog_compare_raw};
         cal_compare_result <= next_compare_result;
      end
   end

   // ----------------------------------------
   // analog controls and pin priority
   // ----------------------------------------
   always @(posedge clock) begin
      if (reset) begin
         amp_config <= 4'h0;
         amp_gain <= 8'h00;
         pin_digital_disable <= 1'b0;
      end else begin
         amp_config <= next_config;
         amp_gain <= next_gain;
         // analog use wins over any digital pin setting
         pin_digital_disable <= amp_enable;
      end
   end

   // ----------------------------------------
   // read back
   // ----------------------------------------
   assign control_value = {amp_enable, 1'b0, amp_output_enable, amp_function_select,
      internal_gain_select};
   assign calibration_value = {cal_compare_result, cal_mode_select, cal_reference_select,
      offset_trim};

   always @* begin
      if (control_hit) begin
         next_rdata = control_value;
      end else if (calibration_hit) begin
         next_rdata = calibration_value;
      end else begin
         next_rdata = 8'h00;
      end
   end

   always @(posedge clock) begin
      if (reset) begin
         sfr_rdata <= `OTC_CONTROL_RESET;
      end else begin
         sfr_rdata <= next_rdata;
      end
   end
endmodule // otc_opamp_trim_control

// File: rtl/otc_defines.vh
// constants for the amplifier trim control block
`ifndef OTC_DEFINES_VH
`define OTC_DEFINES_VH
// ----------------------------------------
// register addresses
// ----------------------------------------
`define OTC_ADDR_CONTROL 8'hEE
`define OTC_ADDR_CALIBRATION 8'hEF
// ----------------------------------------
// field positions
// ----------------------------------------
`define OTC_CTL_ENABLE 7
`define OTC_CTL_OUT_EN 5
`define OTC_CTL_FUNC_HI 4
`define OTC_CTL_FUNC_LO 3
`define OTC_CTL_GAIN_HI 2
`define OTC_CTL_GAIN_LO 0
`define OTC_CAL_COMPARE 7
`define OTC_CAL_MODE 6
`define OTC_CAL_REF 5
`define OTC_CAL_TRIM_HI 4
`define OTC_CAL_TRIM_LO 0
// ----------------------------------------
// reset values and the calibration compare function code
// ----------------------------------------
`define OTC_CONTROL_RESET 8'h00
`define OTC_CAL_FLAGS_RESET 3'h0
`define OTC_FUNC_CAL_COMPARE 2'h0
`endif

// File: rtl/otc_config_decode.v
// decode of function select and gain into one-hot analog switch controls
`timescale 1ns/1ps
module otc_config_decode (
   // configuration
   input wire [1:0] function_select,
   input wire [2:0] gain_select,
   // decoded controls
   output wire [3:0] config_onehot,
   output wire [7:0] gain_onehot
);
   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1) begin : g_cfg
         assign config_onehot[i] = (function_select == i);
      end
      // code order 20X,25X,30X,35X,100X,105X,110X,115X
      for (i = 0; i < 8; i = i + 1) begin : g_gain
         assign gain_onehot[i] = (gain_select == i);
      end
   endgenerate
endmodule // otc_config_decode

// File: test/otc_props.sv
// port assertions for the amplifier trim control
`timescale 1ns/1ps
module otc_props (
   // clock and reset
   input wire clock,
   input wire reset,
   // register port
   input wire [7:0] sfr_addr,
   input wire sfr_write,
   input wire [7:0] sfr_wdata,
   // analog controls
   input wire amp_enable,
   input wire [3:0] amp_config,
   input wire [7:0] amp_gain,
   input wire cal_mode_select,
   input wire cal_reference_select,
   input wire [4:0] offset_trim,
   input wire pin_digital_disable
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   wire ctl_wr = sfr_write && sfr_addr == 8'hEE;
   wire cal_wr = sfr_write && sfr_addr == 8'hEF;
   // decoded outputs lag the register by one more cycle
   sequence s_ctl_settle;
      ctl_wr ##1 !ctl_wr;
   endsequence
   property p_enable;
      ctl_wr |=> amp_enable == $past(sfr_wdata[7]);
   endproperty
   a_enable: assert property (p_enable) else $error("enable bit not taken");
   property p_pins;
      !$past(reset) |-> pin_digital_disable == $past(amp_enable);
   endproperty
   a_pins: assert property (p_pins) else $error("pin disable wrong");
   property p_config;
      s_ctl_settle |=> amp_config == (4'h1 << $past(sfr_wdata[4:3], 2));
   endproperty
   a_config: assert property (p_config) else $error("config decode wrong");
   property p_gain;
      s_ctl_settle |=> amp_gain == (8'h01 << $past(sfr_wdata[2:0], 2));
   endproperty
   a_gain: assert property (p_gain) else $error("gain decode wrong");
   property p_mode;
      cal_wr |=> cal_mode_select == $past(sfr_wdata[6]);
   endproperty
   a_mode: assert property (p_mode) else $error("mode bit not taken");
   property p_ref;
      cal_wr |=> cal_reference_select == $past(sfr_wdata[5]);
   endproperty
   a_ref: assert property (p_ref) else $error("reference bit not taken");
   property p_trim_hold;
      cal_wr && !cal_mode_select && !$past(reset) |=> $stable(offset_trim);
   endproperty
   a_trim_hold: assert property (p_trim_hold) else $error("trim changed");
   property p_trim_take;
      cal_wr && cal_mode_select |=> offset_trim == $past(sfr_wdata[4:0]);
   endproperty
   a_trim_take: assert property (p_trim_take) else $error("trim not taken");
endmodule // otc_props
bind otc_opamp_trim_control otc_props u_props (.clock(clock), .reset(reset),
   .sfr_addr(sfr_addr), .sfr_write(sfr_write), .sfr_wdata(sfr_wdata),
   .amp_enable(amp_enable), .amp_config(amp_config), .amp_gain(amp_gain),
   .cal_mode_select(cal_mode_select), .cal_reference_select(cal_reference_select),
   .offset_trim(offset_trim), .pin_digital_disable(pin_digital_disable));

// File: test/tb_opamp_trim_control.sv
// self-checking bench for the amplifier trim control
`timescale 1ns/1ps
module tb_opamp_trim_control;
   logic clock = 0, reset = 1, sfr_write = 0, rd_req = 0, analog_compare_raw = 0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, v;
   logic [4:0] factory_trim = 5'h15;
   logic [31:0] seed = 32'h66C1;
   logic [7:0] exp_q[$];
   int fail_count = 0, comparisons = 0;
   wire [7:0] sfr_rdata, amp_gain;
   wire [3:0] amp_config;
   wire [4:0] offset_trim;
   wire amp_enable, amp_output_enable, cal_mode_select, cal_reference_select, pin_digital_disable;
   otc_opamp_trim_control u_dut (.clock(clock), .reset(reset), .sfr_addr(sfr_addr),
      .sfr_write(sfr_write), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .factory_trim(factory_trim), .analog_compare_raw(analog_compare_raw),
      .amp_enable(amp_enable), .amp_output_enable(amp_output_enable),
      .amp_config(amp_config), .amp_gain(amp_gain), .cal_mode_select(cal_mode_select),
      .cal_reference_select(cal_reference_select), .offset_trim(offset_trim),
      .pin_digital_disable(pin_digital_disable));
   initial forever #2 clock = ~clock;
   function automatic [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input [7:0] e, input [7:0] s, input string n);
      comparisons++;
      if (e !== s) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic finish_test;
      if (fail_count == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic wr(input [7:0] a, input [7:0] d);
      @(negedge clock);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_write = 1;
      rd_req = 0;
   endtask
   task automatic rd(input [7:0] a, input [7:0] e);
      @(negedge clock);
      sfr_addr = a;
      sfr_write = 0;
      rd_req = 1;
      exp_q.push_back(e);
   endtask
   task automatic idle(input int n);
      repeat (n) begin
         @(negedge clock);
         sfr_write = 0;
         rd_req = 0;
      end
   endtask
   // read data is registered, so it is judged just after the sampling edge
   always @(posedge clock) if (rd_req) begin
      #1 chk(exp_q.pop_front(), sfr_rdata, "read data");
   end
   initial begin
      repeat (5) @(negedge clock);
      reset = 0;
      rd(8'hEF, 8'h15);
      rd(8'hEE, 8'h00);
      chk(8'h00, {7'h0, amp_enable}, "enable");
      wr(8'hEF, 8'h40);
      for (int i = 0; i < 32; i++) begin
         wr(8'hEF, 8'h40 | i[7:0]);
         rd(8'hEF, 8'h40 | i[7:0]);
      end
      wr(8'hEF, 8'h1F);
      wr(8'hEF, 8'h23);
      rd(8'hEF, 8'h3F);
      chk(8'h1F, {3'h0, offset_trim}, "trim");
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         v = {seed[7], 1'b0, seed[5], i[1:0], i[2:0]};
         wr(8'hEE, v);
         rd(8'hEE, v);
         idle(2);
         chk(8'h01 << i[1:0], {4'h0, amp_config}, "config");
         chk(8'h01 << i[2:0], amp_gain, "gain");
         chk({7'h0, v[7]}, {7'h0, pin_digital_disable}, "pin disable");
         chk({7'h0, v[5]}, {7'h0, amp_output_enable}, "output enable");
      end
      wr(8'hEE, 8'hA0);
      wr(8'hEF, 8'h5F);
      analog_compare_raw = 1;
      idle(8);
      rd(8'hEF, 8'hDF);
      wr(8'hEE, 8'h80);
      idle(8);
      rd(8'hEF, 8'h5F);
      idle(1);
      reset = 1;
      idle(2);
      reset = 0;
      rd(8'hEF, 8'h1F);
      idle(2);
      finish_test;
   end
   initial begin
      #5000;
      fail_count++;
      finish_test;
   end
endmodule // tb_opamp_trim_control
